// ### common/pesd_pkg.sv
// Purpose: shared constants and carriers for the performance event select decoder
// Assumes: event code is a 6-bit selector; at most two occurrences per pipe per clock
// Notes: per-clock increment is a small count added by the counter outside
package pesd_pkg;
	localparam int CODE_W = 6;
	localparam int INC_W = 3;
	localparam logic [CODE_W-1:0] EV_SEG_LOAD = 6'h0F;
	localparam logic [CODE_W-1:0] EV_RSVD_A = 6'h10;
	localparam logic [CODE_W-1:0] EV_RSVD_B = 6'h11;
	localparam logic [CODE_W-1:0] EV_BRANCHES = 6'h12;
	localparam logic [CODE_W-1:0] EV_TARGET_HIT = 6'h13;
	localparam logic [CODE_W-1:0] EV_TAKEN_OR_HIT = 6'h14;
	localparam logic [CODE_W-1:0] EV_PIPE_FLUSH = 6'h15;
	localparam logic [CODE_W-1:0] EV_INSTR_EXEC = 6'h16;
	localparam logic [CODE_W-1:0] EV_INSTR_EXEC_V = 6'h17;
	localparam logic [CODE_W-1:0] EV_BUS_BUSY = 6'h18;
	localparam logic [CODE_W-1:0] EV_WBUF_STALL = 6'h19;
	localparam logic [INC_W-1:0] INC_ZERO = 3'h0;

	// per-pipe status strobes, one-cycle pulses except the level flags
	typedef struct packed {
		logic seg_load;        // any segment or descriptor table/task reg write
		logic seg_priv_change; // far transfer / task switch with privilege change
		logic branch_exec;     // executed branch of any kind, taken or not
		logic branch_taken;    // executed branch that was taken
		logic serialize;       // serializing instruction (counts as taken branch)
		logic verify_access;   // verify read/write access instruction
		logic seg_desc_branch; // descriptor load treated as a branch
		logic target_hit;      // target buffer hit on executed instruction
		logic flush;           // pipeline flush of any cause
		logic flush_serial;    // flush caused only by serialization
		logic instr_retire;    // instruction completed
		logic rep_iter;        // further iteration of a repeat string loop
		logic halt_cycle;      // staying halted after a halt instruction
		logic handler_entry;   // interrupt, exception or fault handler invocation
	} pesd_pipe_t;

	typedef struct packed {
		logic bus_cycle;       // bus cycle in progress
		logic hold_ack;        // hold_acknowledge_pin
		logic addr_hold;       // address_hold_pin
		logic back_off;        // back_off_pin
		logic wbuf_stall;      // pipe stalled, write buffers full
		logic wbuf_stall_io;   // the stall is for an I/O access
	} pesd_bus_t;
endpackage

// ### hdl/pesd_decode.sv
// Purpose: selects and qualifies core status strobes into a per-clock counter increment
// Assumes: strobes synchronous to clock_i; u pipe is pipe 0, paired pipe is pipe 1
// Notes: increment_o is registered, one clock after the qualifying strobes
`timescale 1ns/1ns
`default_nettype none
module pesd_decode
(
	input wire logic clock_i,
	input wire logic srst_i,
	input wire logic [pesd_pkg::CODE_W-1:0] event_code_i,
	input wire pesd_pkg::pesd_pipe_t u_pipe_i,
	input wire pesd_pkg::pesd_pipe_t v_pipe_i,
	input wire pesd_pkg::pesd_bus_t bus_i,
	output logic [pesd_pkg::INC_W-1:0] increment_o
);
	import pesd_pkg::*;

	localparam int NUM_PIPES = 2;
	localparam logic [INC_W-1:0] INC_ONE = 3'h1;
	localparam logic [INC_W-1:0] INC_TWO = 3'h2;
	localparam logic [INC_W-1:0] INC_MAX = 3'h4;

	logic [INC_W-1:0] increment_reg;
	logic [INC_W-1:0] increment_next;
	logic [INC_W-1:0] pipe_cnt [NUM_PIPES];
	pesd_pipe_t pipes [NUM_PIPES];

	assign pipes[0] = u_pipe_i;
	assign pipes[1] = v_pipe_i;

	// per-pipe count for the pipe-related event codes
	genvar g;
	generate
		for (g = 0; g < NUM_PIPES; g++)
		begin : g_pipe
			always_comb
			begin
				pesd_pipe_t p;
				p = pipes[g];
				pipe_cnt[g] = INC_ZERO;
				unique case (event_code_i)
					EV_SEG_LOAD:
						pipe_cnt[g] = INC_W'(p.seg_load) + INC_W'(p.seg_load & p.seg_priv_change);
					EV_BRANCHES:
						pipe_cnt[g] = INC_W'(p.branch_exec | p.serialize | p.verify_access
							| p.seg_desc_branch | p.handler_entry);
					EV_TARGET_HIT:
						pipe_cnt[g] = INC_W'(p.target_hit & p.instr_retire);
					EV_TAKEN_OR_HIT:
						pipe_cnt[g] = INC_W'(p.branch_taken | p.target_hit);
					EV_PIPE_FLUSH:
						pipe_cnt[g] = INC_W'(p.flush & ~p.flush_serial);
					EV_INSTR_EXEC, EV_INSTR_EXEC_V:
						pipe_cnt[g] = INC_W'((p.instr_retire & ~p.rep_iter & ~p.halt_cycle)
							| p.handler_entry);
					default:
						pipe_cnt[g] = INC_ZERO;
				endcase
			end
		end
	endgenerate

	always_comb
	begin
		increment_next = pipe_cnt[0] + pipe_cnt[1];
		unique case (event_code_i)
			EV_INSTR_EXEC_V:
				increment_next = pipe_cnt[1];
			EV_BUS_BUSY:
				increment_next = INC_W'(bus_i.bus_cycle | bus_i.hold_ack | bus_i.addr_hold
					| bus_i.back_off);
			EV_WBUF_STALL:
				increment_next = INC_W'(bus_i.wbuf_stall & ~bus_i.wbuf_stall_io);
			EV_RSVD_A, EV_RSVD_B:
				increment_next = INC_ZERO;
			default:
				increment_next = pipe_cnt[0] + pipe_cnt[1];
		endcase
		if (event_code_i < EV_SEG_LOAD || event_code_i > EV_WBUF_STALL)
			increment_next = INC_ZERO;
	end

	always_ff @(posedge clock_i)
	begin
		if (srst_i)
			increment_reg <= INC_ZERO;
		else
			increment_reg <= increment_next;
	end

	assign increment_o = increment_reg;

	sequence s_priv_seg;
		event_code_i == EV_SEG_LOAD && u_pipe_i.seg_load && u_pipe_i.seg_priv_change
			&& !v_pipe_i.seg_load;
	endsequence

	chk_seg_double: assert property (@(posedge clock_i) disable iff (srst_i)
		s_priv_seg |=> increment_o == INC_TWO)
		else $error("privilege-changing segment load not counted twice");

	chk_reserved_zero: assert property (@(posedge clock_i) disable iff (srst_i)
		(event_code_i == EV_RSVD_A || event_code_i == EV_RSVD_B) |=> increment_o == INC_ZERO)
		else $error("reserved code produced an increment");

	chk_branch_count: assert property (@(posedge clock_i) disable iff (srst_i)
		(event_code_i == EV_BRANCHES && u_pipe_i.branch_exec && v_pipe_i.branch_exec)
		|=> increment_o == INC_TWO)
		else $error("dual branch not summed");

	chk_serial_flush: assert property (@(posedge clock_i) disable iff (srst_i)
		(event_code_i == EV_PIPE_FLUSH && u_pipe_i.flush_serial && v_pipe_i.flush_serial)
		|=> increment_o == INC_ZERO)
		else $error("serializing flush counted");

	chk_halt_once: assert property (@(posedge clock_i) disable iff (srst_i)
		(event_code_i == EV_INSTR_EXEC && u_pipe_i.halt_cycle && !u_pipe_i.handler_entry
			&& !v_pipe_i.instr_retire && !v_pipe_i.handler_entry) |=> increment_o == INC_ZERO)
		else $error("halted clock counted as instruction");

	chk_vpipe_only: assert property (@(posedge clock_i) disable iff (srst_i)
		(event_code_i == EV_INSTR_EXEC_V && !v_pipe_i.instr_retire && !v_pipe_i.handler_entry)
		|=> increment_o == INC_ZERO)
		else $error("paired pipe count includes first pipe");

	chk_bus_busy: assert property (@(posedge clock_i) disable iff (srst_i)
		(event_code_i == EV_BUS_BUSY && bus_i.back_off) [*2] |=> increment_o == INC_ONE)
		else $error("back-off clock not counted");

	chk_wbuf_io: assert property (@(posedge clock_i) disable iff (srst_i)
		(event_code_i == EV_WBUF_STALL && bus_i.wbuf_stall_io) |=> increment_o == INC_ZERO)
		else $error("I/O stall counted");

	chk_target_hit: assert property (@(posedge clock_i) disable iff (srst_i)
		(event_code_i == EV_TARGET_HIT && u_pipe_i.target_hit && u_pipe_i.instr_retire
			&& !v_pipe_i.target_hit) |=> increment_o == INC_ONE)
		else $error("executed target hit not counted");

	sequence s_plain_seg;
		event_code_i == EV_SEG_LOAD && u_pipe_i.seg_load && !u_pipe_i.seg_priv_change
			&& !v_pipe_i.seg_load;
	endsequence

	chk_seg_single: assert property (@(posedge clock_i) disable iff (srst_i)
		s_plain_seg |=> increment_o == INC_ONE)
		else $error("plain segment load not counted once");

	sequence s_both_priv_seg;
		event_code_i == EV_SEG_LOAD && u_pipe_i.seg_load && u_pipe_i.seg_priv_change
			&& v_pipe_i.seg_load && v_pipe_i.seg_priv_change;
	endsequence

	chk_sum_all: assert property (@(posedge clock_i) disable iff (srst_i)
		s_both_priv_seg |=> increment_o == INC_MAX)
		else $error("doubled loads in both pipes not summed");

	// no branch-like flag in the paired pipe
	sequence s_v_no_branch;
		!v_pipe_i.branch_exec && !v_pipe_i.serialize && !v_pipe_i.verify_access
			&& !v_pipe_i.seg_desc_branch && !v_pipe_i.handler_entry;
	endsequence

	sequence s_not_taken;
		event_code_i == EV_BRANCHES && u_pipe_i.branch_exec && !u_pipe_i.branch_taken;
	endsequence

	chk_not_taken: assert property (@(posedge clock_i) disable iff (srst_i)
		(s_not_taken and s_v_no_branch) |=> increment_o == INC_ONE)
		else $error("not-taken branch not counted");

	sequence s_branch_like;
		event_code_i == EV_BRANCHES && (u_pipe_i.serialize || u_pipe_i.verify_access
			|| u_pipe_i.seg_desc_branch || u_pipe_i.handler_entry);
	endsequence

	chk_branch_like: assert property (@(posedge clock_i) disable iff (srst_i)
		(s_branch_like and s_v_no_branch) |=> increment_o == INC_ONE)
		else $error("branch-like event not counted once");

	sequence s_u_no_branch;
		event_code_i == EV_BRANCHES && !u_pipe_i.branch_exec && !u_pipe_i.serialize
			&& !u_pipe_i.verify_access && !u_pipe_i.seg_desc_branch && !u_pipe_i.handler_entry;
	endsequence

	chk_no_branch: assert property (@(posedge clock_i) disable iff (srst_i)
		(s_u_no_branch and s_v_no_branch) |=> increment_o == INC_ZERO)
		else $error("branch counted without execution");

	sequence s_taken_and_hit;
		event_code_i == EV_TAKEN_OR_HIT && u_pipe_i.branch_taken && u_pipe_i.target_hit
			&& !v_pipe_i.branch_taken && !v_pipe_i.target_hit;
	endsequence

	chk_taken_or_hit: assert property (@(posedge clock_i) disable iff (srst_i)
		s_taken_and_hit |=> increment_o == INC_ONE)
		else $error("taken branch with hit not counted once");

	sequence s_dual_flush;
		event_code_i == EV_PIPE_FLUSH && u_pipe_i.flush && !u_pipe_i.flush_serial
			&& v_pipe_i.flush && !v_pipe_i.flush_serial;
	endsequence

	chk_dual_flush: assert property (@(posedge clock_i) disable iff (srst_i)
		s_dual_flush |=> increment_o == INC_TWO)
		else $error("flushes in both pipes not summed");

	sequence s_dual_retire;
		event_code_i == EV_INSTR_EXEC && u_pipe_i.instr_retire && !u_pipe_i.rep_iter
			&& !u_pipe_i.halt_cycle && v_pipe_i.instr_retire && !v_pipe_i.rep_iter
			&& !v_pipe_i.halt_cycle;
	endsequence

	chk_dual_retire: assert property (@(posedge clock_i) disable iff (srst_i)
		s_dual_retire |=> increment_o == INC_TWO)
		else $error("two instructions in one clock not counted");

	// paired pipe contributes no instruction
	sequence s_v_no_instr;
		!v_pipe_i.instr_retire && !v_pipe_i.handler_entry;
	endsequence

	sequence s_handler_only;
		event_code_i == EV_INSTR_EXEC && u_pipe_i.handler_entry && !u_pipe_i.instr_retire;
	endsequence

	chk_handler_instr: assert property (@(posedge clock_i) disable iff (srst_i)
		(s_handler_only and s_v_no_instr) |=> increment_o == INC_ONE)
		else $error("handler invocation not counted as instruction");

	sequence s_rep_iter;
		event_code_i == EV_INSTR_EXEC && u_pipe_i.rep_iter && !u_pipe_i.handler_entry;
	endsequence

	chk_rep_once: assert property (@(posedge clock_i) disable iff (srst_i)
		(s_rep_iter and s_v_no_instr) |=> increment_o == INC_ZERO)
		else $error("repeat iteration counted again");

	sequence s_v_halted;
		event_code_i == EV_INSTR_EXEC && v_pipe_i.halt_cycle && !v_pipe_i.handler_entry
			&& !u_pipe_i.instr_retire && !u_pipe_i.handler_entry;
	endsequence

	chk_halt_v_once: assert property (@(posedge clock_i) disable iff (srst_i)
		s_v_halted |=> increment_o == INC_ZERO)
		else $error("halted clock in paired pipe counted");

	sequence s_v_retire;
		event_code_i == EV_INSTR_EXEC_V && v_pipe_i.instr_retire && !v_pipe_i.rep_iter
			&& !v_pipe_i.halt_cycle;
	endsequence

	chk_vpipe_count: assert property (@(posedge clock_i) disable iff (srst_i)
		s_v_retire |=> increment_o == INC_ONE)
		else $error("paired pipe instruction not counted once");

	sequence s_hold_only;
		event_code_i == EV_BUS_BUSY && bus_i.hold_ack && !bus_i.bus_cycle;
	endsequence

	chk_hold_clock: assert property (@(posedge clock_i) disable iff (srst_i)
		s_hold_only |=> increment_o == INC_ONE)
		else $error("hold acknowledge clock not counted");

	sequence s_wbuf_stall;
		event_code_i == EV_WBUF_STALL && bus_i.wbuf_stall && !bus_i.wbuf_stall_io;
	endsequence

	chk_wbuf_stall: assert property (@(posedge clock_i) disable iff (srst_i)
		s_wbuf_stall |=> increment_o == INC_ONE)
		else $error("write buffer stall clock not counted");

	sequence s_out_of_range;
		event_code_i < EV_SEG_LOAD || event_code_i > EV_WBUF_STALL;
	endsequence

	chk_out_of_range: assert property (@(posedge clock_i) disable iff (srst_i)
		s_out_of_range |=> increment_o == INC_ZERO)
		else $error("unsupported code produced an increment");

	chk_reset_clear: assert property (@(posedge clock_i)
		srst_i |=> increment_o == INC_ZERO)
		else $error("increment not cleared by reset");
endmodule // pesd_decode
`default_nettype wire

// ### verification/pesd_core_model.sv
// Purpose: core strobe source standing in front of the event decoder
// Assumes: raw strobe requests come from the bench each clock
// Notes: keeps the strobes self-consistent the way a real core reports them
`timescale 1ns/1ns
`default_nettype none
module pesd_core_model
(
	input wire pesd_pkg::pesd_pipe_t u_raw_i,
	input wire pesd_pkg::pesd_pipe_t v_raw_i,
	output var pesd_pkg::pesd_pipe_t u_pipe_o,
	output var pesd_pkg::pesd_pipe_t v_pipe_o
);
	import pesd_pkg::*;
	// privilege change only with a load; branch-like events are executed taken branches
	function automatic pesd_pipe_t fix(input pesd_pipe_t p);
		pesd_pipe_t q;
		q = p;
		q.seg_priv_change = p.seg_load & p.seg_priv_change;
		q.branch_taken = p.branch_taken | p.serialize | p.verify_access | p.seg_desc_branch
			| p.handler_entry;
		q.branch_exec = p.branch_exec | q.branch_taken;
		q.target_hit = p.target_hit & p.instr_retire;
		return q;
	endfunction
	assign u_pipe_o = fix(u_raw_i);
	assign v_pipe_o = fix(v_raw_i);
endmodule // pesd_core_model
`default_nettype wire

// ### verification/pesd_decode_tb.sv
// Purpose: self-checking bench for the event decoder
// Assumes: one-clock latency from strobes to increment
// Notes: corner patterns for every code, then seeded random traffic
`timescale 1ns/1ns
`default_nettype none
module pesd_decode_tb;
	import pesd_pkg::*;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic [CODE_W-1:0] code = 6'h00;
	pesd_pipe_t u_raw = '0, v_raw = '0, u_pipe, v_pipe;
	pesd_bus_t bus = '0;
	logic [INC_W-1:0] increment;
	int num_errors = 0, samples_checked = 0, cycles = 0;
	logic [31:0] r;
	always #5 clock = ~clock;
	pesd_core_model MODEL (.u_raw_i(u_raw), .v_raw_i(v_raw), .u_pipe_o(u_pipe), .v_pipe_o(v_pipe));
	pesd_decode DUT (.clock_i(clock), .srst_i(srst), .event_code_i(code), .u_pipe_i(u_pipe),
		.v_pipe_i(v_pipe), .bus_i(bus), .increment_o(increment));
	function automatic logic [INC_W-1:0] pc(input logic [CODE_W-1:0] c, input pesd_pipe_t p);
		case (c)
			EV_SEG_LOAD: return p.seg_load ? (p.seg_priv_change ? 3'h2 : 3'h1) : INC_ZERO;
			EV_BRANCHES: return {2'h0, p.branch_exec};
			EV_TARGET_HIT: return {2'h0, p.target_hit & p.instr_retire};
			EV_TAKEN_OR_HIT: return {2'h0, p.branch_taken | p.target_hit};
			EV_PIPE_FLUSH: return {2'h0, p.flush & ~p.flush_serial};
			EV_INSTR_EXEC, EV_INSTR_EXEC_V:
				return {2'h0, (p.instr_retire & ~p.rep_iter & ~p.halt_cycle) | p.handler_entry};
			default: return INC_ZERO;
		endcase
	endfunction
	function automatic logic [INC_W-1:0] expf(input logic [CODE_W-1:0] c, input pesd_pipe_t u,
		input pesd_pipe_t v, input pesd_bus_t b);
		if (c == EV_INSTR_EXEC_V)
			return pc(c, v);
		if (c == EV_BUS_BUSY)
			return {2'h0, b.bus_cycle | b.hold_ack | b.addr_hold | b.back_off};
		if (c == EV_WBUF_STALL)
			return {2'h0, b.wbuf_stall & ~b.wbuf_stall_io};
		return pc(c, u) + pc(c, v);
	endfunction
	task automatic stop_test();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic [INC_W-1:0] got, input logic [INC_W-1:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask
	task automatic step(input logic [CODE_W-1:0] c, input pesd_pipe_t u, input pesd_pipe_t v,
		input pesd_bus_t b);
		logic [INC_W-1:0] e;
		@(posedge clock);
		e = expf(code, u_pipe, v_pipe, bus);
		#1;
		check(increment, e);
		code = c;
		u_raw = u;
		v_raw = v;
		bus = b;
	endtask
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 6000)
		begin
			num_errors++;
			stop_test();
		end
	end
	initial
	begin
		void'($urandom(25662));
		repeat (20) @(posedge clock);
		#1 srst = 1'b0;
		// every code with all strobes idle
		for (int i = 0; i < 13; i++)
			step(6'h0E + 6'(i), '0, '0, '0);
		// all strobes high, then high with branch_taken, serialize, rep_iter, halt_cycle and wbuf_stall_io low
		for (int i = 0; i < 26; i++)
		begin
			r = (i < 13) ? 32'hFFFFFFFF : 32'hFFFFF9F9;
			step(6'h0E + 6'(i % 13), r[13:0], r[13:0], pesd_bus_t'(i < 13 ? 6'h3F : 6'h3E));
		end
		for (int i = 0; i < 3000; i++)
		begin
			r = $urandom;
			step(6'h0E + 6'($urandom_range(12)), r[13:0], r[27:14], r[31:26]);
		end
		step(6'h00, '0, '0, '0);
		step(6'h00, '0, '0, '0);
		stop_test();
	end
endmodule // pesd_decode_tb
`default_nettype wire
